// ===== pkg/spcb_pkg.sv
`default_nettype none
package spcb_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] SPCB_CTRL_B_IDX = 12'h06e;
  localparam logic [11:0] SPCB_DTAG_IDX = 12'h070;
  localparam logic [11:0] SPCB_CTRL_C_IDX = 12'h072;
  localparam logic [13:0] SPCB_CTRL_B_ADDR = {SPCB_CTRL_B_IDX, 2'b00};
  localparam logic [13:0] SPCB_DTAG_ADDR = {SPCB_DTAG_IDX, 2'b00};
  localparam logic [13:0] SPCB_CTRL_C_ADDR = {SPCB_CTRL_C_IDX, 2'b00};
  // ---------------------------------------------------------------
  // Reset values and write masks
  // ---------------------------------------------------------------
  localparam logic [15:0] SPCB_CTRL_B_RST = 16'h0607;
  localparam logic [15:0] SPCB_CTRL_B_MASK = 16'h7fef;
  localparam logic [15:0] SPCB_DTAG_RST = 16'h0001;
  localparam logic [15:0] SPCB_DTAG_MASK = 16'hffff;
  localparam logic [15:0] SPCB_CTRL_C_RST = 16'h0000;
  localparam logic [15:0] SPCB_CTRL_C_MASK = 16'h000f;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SPCB_B_VFILT = 14;
  localparam int SPCB_B_NPVID = 13;
  localparam int SPCB_B_FFC = 12;
  localparam int SPCB_B_BP = 11;
  localparam int SPCB_B_TXEN = 10;
  localparam int SPCB_B_RXEN = 9;
  localparam int SPCB_B_LRNDIS = 8;
  localparam int SPCB_B_SNIFP = 7;
  localparam int SPCB_B_RXSNF = 6;
  localparam int SPCB_B_TXSNF = 5;
  localparam int SPCB_B_PCEIL = 3;
  localparam int SPCB_B_MEMB_HI = 2;
  localparam int SPCB_T_UP_HI = 15;
  localparam int SPCB_T_UP_LO = 13;
  localparam int SPCB_T_CFI = 12;
  localparam int SPCB_T_VID_HI = 11;
  localparam int SPCB_C_MODE_HI = 3;
  localparam int SPCB_C_MODE_LO = 2;
  localparam int SPCB_C_IFG = 1;
  localparam int SPCB_C_PRE = 0;
  // ---------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------
  localparam logic [11:0] SPCB_NULL_VID = 12'h000;
  localparam logic [4:0] SPCB_IFG_BYTES = 5'h0c;
  localparam logic [4:0] SPCB_PRE_BYTES = 5'h08;
  localparam logic [2:0] SPCB_PORT_SELF = 3'h1;
  typedef enum logic [1:0] {
    SPCB_LIM_ALL = 2'b00,
    SPCB_LIM_BMF = 2'b01,
    SPCB_LIM_BM = 2'b10,
    SPCB_LIM_B = 2'b11
  } spcb_lim_t;
endpackage : spcb_pkg
`default_nettype wire

// ===== rtl/spcb_bank.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module spcb_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Ingress frame descriptor
  input wire logic rx_valid,
  input wire logic rx_tagged,
  input wire logic [11:0] rx_vid,
  input wire logic [2:0] rx_prio,
  input wire logic [2:0] rx_vlan_members,
  input wire logic rx_bcast,
  input wire logic rx_mcast,
  input wire logic rx_flood,
  input wire logic tx_valid,
  input wire logic an_flow_ctrl,
  // Frame decisions
  output logic rx_accept,
  output logic rx_drop,
  output logic [11:0] rx_eff_vid,
  output logic [2:0] rx_eff_prio,
  output logic rx_learn,
  output logic rx_monitored,
  output logic tx_monitored,
  output logic rx_rate_count,
  output logic [4:0] rate_extra_bytes,
  output logic [15:0] egress_tag,
  // Static controls
  output logic [2:0] port_members,
  output logic flow_ctrl_en,
  output logic back_pressure_en,
  output logic tx_enable,
  output logic rx_enable,
  output logic sniffer_port
);
  import spcb_pkg::*;

  // -------------------------------------------------------------
  // Register file
  // -------------------------------------------------------------
  logic [15:0] ctrl_b_reg;
  logic [15:0] dtag_reg;
  logic [15:0] ctrl_c_reg;
  logic wr_en;
  logic hit_b;
  logic hit_t;
  logic hit_c;

  function automatic logic [15:0] spcb_merge(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] st,
      input logic [15:0] mask);
    logic [15:0] nv;
    nv = old;
    if (st[0]) begin
      nv[7:0] = wd[7:0];
    end
    if (st[1]) begin
      nv[15:8] = wd[15:8];
    end
    return nv & mask;
  endfunction : spcb_merge

  function automatic logic spcb_addr_hit(input logic [13:0] a,
      input logic [13:0] target);
    return a == target;
  endfunction : spcb_addr_hit

  logic wr_b;
  logic wr_t;
  logic wr_c;
  assign hit_b = spcb_addr_hit(paddr, SPCB_CTRL_B_ADDR);
  assign hit_t = spcb_addr_hit(paddr, SPCB_DTAG_ADDR);
  assign hit_c = spcb_addr_hit(paddr, SPCB_CTRL_C_ADDR);
  assign wr_b = wr_en & hit_b;
  assign wr_t = wr_en & hit_t;
  assign wr_c = wr_en & hit_c;
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_b | hit_t | hit_c);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_reg <= SPCB_CTRL_B_RST;
    end else if (wr_b) begin
      ctrl_b_reg <= spcb_merge(ctrl_b_reg, pwdata, pstrb,
                               SPCB_CTRL_B_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtag_reg <= SPCB_DTAG_RST;
    end else if (wr_t) begin
      dtag_reg <= spcb_merge(dtag_reg, pwdata, pstrb, SPCB_DTAG_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_c_reg <= SPCB_CTRL_C_RST;
    end else if (wr_c) begin
      ctrl_c_reg <= spcb_merge(ctrl_c_reg, pwdata, pstrb,
                               SPCB_CTRL_C_MASK);
    end
  end

  function automatic logic [31:0] spcb_read_word(input logic sel_b,
      input logic sel_t, input logic sel_c, input logic [15:0] vb,
      input logic [15:0] vt, input logic [15:0] vc);
    logic [31:0] res;
    res = 32'h0000_0000;
    if (sel_b) begin
      res = {16'h0000, vb};
    end else if (sel_t) begin
      res = {16'h0000, vt};
    end else if (sel_c) begin
      res = {16'h0000, vc};
    end
    return res;
  endfunction : spcb_read_word

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= spcb_read_word(hit_b, hit_t, hit_c, ctrl_b_reg, dtag_reg,
                               ctrl_c_reg);
    end
  end

  // -------------------------------------------------------------
  // Static controls
  // -------------------------------------------------------------
  logic [2:0] up_prio;
  logic [11:0] def_vid;
  assign up_prio = dtag_reg[SPCB_T_UP_HI:SPCB_T_UP_LO];
  assign def_vid = dtag_reg[SPCB_T_VID_HI:0];
  genvar gi;
  generate
    for (gi = 0; gi <= SPCB_B_MEMB_HI; gi++) begin : g_memb
      assign port_members[gi] = ctrl_b_reg[gi];
    end
  endgenerate
  logic lrn_dis;
  logic rx_snf;
  logic tx_snf;
  logic tx_en_bit;
  assign lrn_dis = ctrl_b_reg[SPCB_B_LRNDIS];
  assign rx_snf = ctrl_b_reg[SPCB_B_RXSNF];
  assign tx_snf = ctrl_b_reg[SPCB_B_TXSNF];
  assign tx_en_bit = ctrl_b_reg[SPCB_B_TXEN];
  assign flow_ctrl_en = ctrl_b_reg[SPCB_B_FFC] | an_flow_ctrl;
  assign back_pressure_en = ctrl_b_reg[SPCB_B_BP];
  assign tx_enable = ctrl_b_reg[SPCB_B_TXEN];
  assign rx_enable = ctrl_b_reg[SPCB_B_RXEN];
  assign sniffer_port = ctrl_b_reg[SPCB_B_SNIFP];
  assign egress_tag = dtag_reg;

  // -------------------------------------------------------------
  // Decision functions
  // -------------------------------------------------------------
  function automatic logic [11:0] spcb_resolve_vid(input logic tagged_in,
      input logic [11:0] vid_in, input logic [11:0] dflt);
    logic [11:0] res;
    res = vid_in;
    if (!tagged_in || vid_in == SPCB_NULL_VID) begin
      res = dflt;
    end
    return res;
  endfunction : spcb_resolve_vid

  function automatic logic spcb_filter_drop(input logic [15:0] cb,
      input logic [2:0] members, input logic [11:0] vid_in,
      input logic [11:0] dflt);
    logic res;
    res = 1'b0;
    if (cb[SPCB_B_VFILT] && (members & SPCB_PORT_SELF) == 3'h0) begin
      res = 1'b1;
    end
    if (cb[SPCB_B_NPVID] && vid_in != dflt) begin
      res = 1'b1;
    end
    if (!cb[SPCB_B_RXEN]) begin
      res = 1'b1;
    end
    return res;
  endfunction : spcb_filter_drop

  function automatic logic spcb_limit_match(input logic [1:0] mode,
      input logic bc, input logic mc, input logic fl);
    logic res;
    res = 1'b1;
    case (spcb_lim_t'(mode))
      SPCB_LIM_ALL: begin
        res = 1'b1;
      end
      SPCB_LIM_BMF: begin
        res = bc | mc | fl;
      end
      SPCB_LIM_BM: begin
        res = bc | mc;
      end
      SPCB_LIM_B: begin
        res = bc;
      end
      default: begin
        res = 1'b1;
      end
    endcase
    return res;
  endfunction : spcb_limit_match

  function automatic logic [4:0] spcb_extra_bytes(input logic [15:0] cc);
    logic [4:0] res;
    res = 5'h00;
    if (cc[SPCB_C_IFG]) begin
      res = res + SPCB_IFG_BYTES;
    end
    if (cc[SPCB_C_PRE]) begin
      res = res + SPCB_PRE_BYTES;
    end
    return res;
  endfunction : spcb_extra_bytes

  function automatic logic [2:0] spcb_prio_ceil(input logic [15:0] cb,
      input logic [2:0] ceil, input logic [2:0] prio);
    logic [2:0] res;
    res = prio;
    if (cb[SPCB_B_PCEIL] && prio > ceil) begin
      res = ceil;
    end
    return res;
  endfunction : spcb_prio_ceil

  // -------------------------------------------------------------
  // Per-frame decisions
  // -------------------------------------------------------------
  logic [11:0] vid_c;
  logic drop_c;
  logic keep_c;
  logic count_c;
  logic [4:0] extra_c;
  logic [2:0] prio_c;

  always_comb begin
    vid_c = spcb_resolve_vid(rx_tagged, rx_vid, def_vid);
    drop_c = spcb_filter_drop(ctrl_b_reg, rx_vlan_members, vid_c, def_vid);
    keep_c = rx_valid & ~drop_c;
    count_c = spcb_limit_match(ctrl_c_reg[SPCB_C_MODE_HI:SPCB_C_MODE_LO],
                               rx_bcast, rx_mcast, rx_flood);
    extra_c = spcb_extra_bytes(ctrl_c_reg);
    prio_c = spcb_prio_ceil(ctrl_b_reg, up_prio, rx_prio);
  end

  // -------------------------------------------------------------
  // Registered frame outputs
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_accept <= 1'b0;
    end else begin
      rx_accept <= keep_c;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_drop <= 1'b0;
    end else begin
      rx_drop <= rx_valid & drop_c;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_eff_vid <= 12'h000;
    end else begin
      rx_eff_vid <= vid_c;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_eff_prio <= 3'h0;
    end else begin
      rx_eff_prio <= prio_c;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_learn <= 1'b0;
    end else begin
      rx_learn <= keep_c & ~lrn_dis;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_monitored <= 1'b0;
    end else begin
      rx_monitored <= keep_c & rx_snf;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_rate_count <= 1'b0;
    end else begin
      rx_rate_count <= rx_valid & count_c;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_monitored <= 1'b0;
    end else begin
      tx_monitored <= tx_valid & tx_en_bit & tx_snf;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_extra_bytes <= 5'h00;
    end else begin
      rate_extra_bytes <= extra_c;
    end
  end
endmodule : spcb_bank
`default_nettype wire

// ===== tb/spcb_bank_sva.sv
`timescale 1ns/100ps
`default_nettype none
module spcb_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_valid,
  input wire logic rx_tagged,
  input wire logic [11:0] rx_vid,
  input wire logic [2:0] rx_prio,
  input wire logic rx_accept,
  input wire logic rx_drop,
  input wire logic [11:0] rx_eff_vid,
  input wire logic [2:0] rx_eff_prio,
  input wire logic rx_learn,
  input wire logic rx_monitored,
  input wire logic tx_valid,
  input wire logic tx_monitored,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic an_flow_ctrl,
  input wire logic flow_ctrl_en,
  input wire logic [4:0] rate_extra_bytes,
  input wire logic [15:0] egress_tag
);
  // ------------------------------
  // Frame decision checks
  // ------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rx_off;
    rx_valid && !rx_enable;
  endsequence
  sequence s_no_vid;
    rx_valid && (!rx_tagged || rx_vid == 12'h000);
  endsequence
  chk_drop_rx_off: assert property (s_rx_off |=> rx_drop && !rx_accept)
    else $error("frame kept with receive off");
  chk_one_verdict: assert property (rx_valid |=> rx_accept ^ rx_drop)
    else $error("accept and drop not exclusive");
  chk_tx_mon_gate: assert property (tx_valid && !tx_enable |=> !tx_monitored)
    else $error("monitored with transmit off");
  chk_flow_force: assert property (an_flow_ctrl |-> flow_ctrl_en)
    else $error("negotiated flow control lost");
  chk_prio_ceil: assert property (rx_valid |=> rx_eff_prio <= $past(rx_prio))
    else $error("priority raised");
  chk_default_vid: assert property (s_no_vid |=> rx_eff_vid == egress_tag[11:0])
    else $error("default vid not used");
  chk_tagged_vid: assert property (
    rx_valid && rx_tagged && rx_vid != 12'h000 |=> rx_eff_vid == $past(rx_vid))
    else $error("tagged vid altered");
  chk_extra_bytes: assert property (
    rate_extra_bytes inside {5'h00, 5'h08, 5'h0c, 5'h14})
    else $error("bad extra byte count");
  chk_learn_drop: assert property (rx_drop |-> !rx_learn && !rx_monitored)
    else $error("dropped frame learned or monitored");
endmodule : spcb_sva
bind spcb_bank spcb_sva u_sva (.*);
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import spcb_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, er, dr, rx_valid = 0, rx_tagged = 0, tx_valid = 0;
  logic rx_bcast = 0, rx_mcast = 0, rx_flood = 0, an_flow_ctrl = 0;
  logic [11:0] rx_vid = 12'h000, rx_eff_vid, v;
  logic [2:0] rx_prio = 3'h0, rx_vlan_members = 3'h0, rx_eff_prio;
  logic [2:0] port_members;
  logic rx_accept, rx_drop, rx_learn, rx_monitored, tx_monitored;
  logic rx_rate_count, flow_ctrl_en, back_pressure_en, tx_enable;
  logic rx_enable, sniffer_port;
  logic [4:0] rate_extra_bytes;
  logic [15:0] egress_tag, b, t, c, lf = 16'hc226;
  int fail_count = 0, total_checks = 0;
  always #12.5 pclk = ~pclk;
  spcb_bank uut (.*);
  // ------------------------------
  // Helpers
  // ------------------------------
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task complete_run;
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  function logic [15:0] nx(input logic [15:0] s);
    for (int i = 0; i < 16; i++) s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    return s;
  endfunction : nx
  task apb(input logic w, input logic [13:0] a, input logic [15:0] d);
    int i;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (i == 16) begin
      fail_count++;
      complete_run;
    end
    @(posedge pclk);
  endtask : apb
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("txen", tx_enable, 1);
    chk("rxen", rx_enable, 1);
    apb(0, SPCB_CTRL_B_ADDR, 0);
    chk("ctrl_b", rd, 32'h0607);
    apb(0, SPCB_DTAG_ADDR, 0);
    chk("dtag", rd, 32'h0001);
    apb(0, SPCB_CTRL_C_ADDR, 0);
    chk("ctrl_c", rd, 32'h0000);
    apb(0, 14'h0004, 0);
    chk("slverr", er, 1);
    apb(1, SPCB_CTRL_C_ADDR, 16'hffff);
    apb(0, SPCB_CTRL_C_ADDR, 0);
    chk("ctrl_c", rd, 32'h000f);
    repeat (200) begin
      lf = nx(lf); b = lf; lf = nx(lf); t = lf; lf = nx(lf); c = lf;
      apb(1, SPCB_CTRL_B_ADDR, b);
      apb(1, SPCB_DTAG_ADDR, t);
      apb(1, SPCB_CTRL_C_ADDR, c);
      b &= 16'h7fef;
      c &= 16'h000f;
      chk("tag", egress_tag, t);
      chk("bp", back_pressure_en, b[11]);
      chk("snif", sniffer_port, b[7]);
      chk("memb", port_members, b[2:0]);
      lf = nx(lf);
      rx_vid <= lf[3] ? 12'h000 : (lf[4] ? t[11:0] : lf[15:4]);
      rx_tagged <= lf[0]; rx_prio <= lf[7:5]; rx_vlan_members <= lf[10:8];
      rx_bcast <= lf[11]; rx_mcast <= lf[12]; rx_flood <= lf[13];
      an_flow_ctrl <= lf[14]; rx_valid <= 1; tx_valid <= 1;
      @(posedge pclk);
      rx_valid <= 0;
      tx_valid <= 0;
      #1;
      v = (!rx_tagged || rx_vid == 12'h000) ? t[11:0] : rx_vid;
      dr = !b[9] || (b[14] && !rx_vlan_members[0]) || (b[13] && v != t[11:0]);
      chk("drop", rx_drop, dr);
      chk("vid", rx_eff_vid, v);
      chk("prio", rx_eff_prio, (b[3] && rx_prio > t[15:13]) ? t[15:13] : rx_prio);
      chk("learn", rx_learn, !dr && !b[8]);
      chk("rxmon", rx_monitored, !dr && b[6]);
      chk("txmon", tx_monitored, b[10] && b[5]);
      chk("fc", flow_ctrl_en, b[12] | an_flow_ctrl);
      chk("bytes", rate_extra_bytes, (c[1] ? 12 : 0) + (c[0] ? 8 : 0));
      chk("accept", rx_accept, !dr);
      chk("txen", tx_enable, b[10]);
      chk("rxen", rx_enable, b[9]);
      if (!dr) chk("rate", rx_rate_count, c[3:2] == 2'b00 || rx_bcast || (c[3:2] != 2'b11 && rx_mcast) || (c[3:2] == 2'b01 && rx_flood));
      @(posedge pclk);
    end
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
